// File: rtl/tcr_config_regs.v
// Configuration register bank of the FSK transceiver with its
// three-wire port, main state decode, bit synchronizer and modulation
// method decode. Assumes all pins are synchronous to clk_sys and that
// sclk runs well below half the clk_sys rate.
//
// Behaviour
// RULE_01 - Main state: 00 power down keeping registers, 01 standby, 10 rx, 11 tx
// RULE_02 - Rx without sync: demodulated data passes straight through, no bit clock
// RULE_03 - Tx without sync: bit clock pin inactive, data passes transparently
// RULE_04 - Sync set: device makes bit clock, syncs rx, drives clock pin in tx
// RULE_05 - Modulation: 00 closed loop, 01 open loop, 10 divider switching
// RULE_06 - Host never writes modulation code 11
// RULE_07 - Host always writes 1 to bias register bit 7
// RULE_08 - Host writes bias bits 6 and 5 as 0 and 1
// RULE_09 - Host writes bias bits 4 and 3 as 1 and 0
// RULE_10 - Host writes bias bits 2 to 0 as 1, 0, 1
// RULE_11 - Error estimate readable as an 8-bit value, bit 7 most significant
// RULE_12 - Error control low bits: off, count up, count down, up minus down; code adds 1 per down pulse in mode 2
// RULE_13 - Host writes reserved bits as 0 and ignores them on read
`timescale 1ns/1ps
`include "tcr_defs.vh"

module tcr_config_regs
#(
    parameter BIT_DIV = `TCR_BIT_DIV
)
(
    clk_sys,
    rstn,
    sclk,
    sle,
    sdata_in,
    sdata_out,
    sdata_oe,
    main_state_hi,
    main_state_lo,
    sync_en,
    mod_method_hi,
    mod_method_lo,
    demod_data,
    fee_up_pulse,
    fee_dn_pulse,
    tx_data_in,
    rx_data,
    tx_data_mod,
    bit_clock_pin_out,
    bit_clock_pin_oe,
    pwr_down,
    xco_on,
    rx_on,
    tx_on,
    pa_on,
    bit_sync_on,
    mod_closed_loop,
    mod_open_loop,
    mod_divider,
    mod_reserved,
    div_alt_sel,
    second_swallow_count,
    second_feedback_count,
    second_reference_count,
    bias_value,
    bias_fault
);
    input wire clk_sys;
    input wire rstn;
    input wire sclk;
    input wire sle;
    input wire sdata_in;
    output reg sdata_out;
    output reg sdata_oe;
    input wire main_state_hi;
    input wire main_state_lo;
    input wire sync_en;
    input wire mod_method_hi;
    input wire mod_method_lo;
    input wire demod_data;
    input wire fee_up_pulse;
    input wire fee_dn_pulse;
    input wire tx_data_in;
    output reg rx_data;
    output reg tx_data_mod;
    output reg bit_clock_pin_out;
    output reg bit_clock_pin_oe;
    output reg pwr_down;
    output reg xco_on;
    output reg rx_on;
    output reg tx_on;
    output reg pa_on;
    output reg bit_sync_on;
    output reg mod_closed_loop;
    output reg mod_open_loop;
    output reg mod_divider;
    output reg mod_reserved;
    output reg div_alt_sel;
    output wire [5:0] second_swallow_count;
    output wire [11:0] second_feedback_count;
    output wire [11:0] second_reference_count;
    output wire [7:0] bias_value;
    output reg bias_fault;

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_HDR = 3'b010;
    localparam [2:0] ST_DATA = 3'b100;
    localparam integer HALF_DIV = BIT_DIV / 2;

    reg [2:0] state_r;
    reg sclk_d_r;
    reg sle_d_r;
    reg [2:0] bit_cnt_r;
    reg [6:0] hdr_sh_r;
    reg [6:0] addr_r;
    reg rd_r;
    reg [6:0] wr_sh_r;
    reg [7:0] rd_sh_r;
    reg wr_stb_r;
    reg [7:0] wr_data_r;
    reg [7:0] a_div_r;
    reg [7:0] n_high_r;
    reg [7:0] n_low_r;
    reg [7:0] m_high_r;
    reg [7:0] m_low_r;
    reg [7:0] bias_r;
    reg [7:0] fee_ctrl_r;
    reg [7:0] rd_mux_nxt;
    reg [15:0] bit_cnt_div_r;
    reg demod_d_r;
    wire [7:0] fee_value;
    wire sclk_rise;
    wire sclk_fall;
    wire sle_rise;
    wire [1:0] main_state;
    wire [1:0] mod_method;
    wire bit_tick;
    wire fee_clear;

    assign sclk_rise = sclk & ~sclk_d_r;
    assign sclk_fall = ~sclk & sclk_d_r;
    assign sle_rise = sle & ~sle_d_r;
    assign main_state = {main_state_hi, main_state_lo};
    assign mod_method = {mod_method_hi, mod_method_lo};

    ////////////////////////////////////////////////////////////////////////
    // Read mux; reserved bits come back as zero
    always @*
    begin
        rd_mux_nxt = 8'h00;
        case (hdr_sh_r)
            `TCR_OFF_A_DIV:
                rd_mux_nxt = a_div_r;
            `TCR_OFF_N_HIGH:
                rd_mux_nxt = n_high_r;
            `TCR_OFF_N_LOW:
                rd_mux_nxt = n_low_r;
            `TCR_OFF_M_HIGH:
                rd_mux_nxt = m_high_r;
            `TCR_OFF_M_LOW:
                rd_mux_nxt = m_low_r;
            `TCR_OFF_BIAS:
                rd_mux_nxt = bias_r;
            `TCR_OFF_FEE_CTRL:
                rd_mux_nxt = fee_ctrl_r;
            `TCR_OFF_FEE_VALUE:
                rd_mux_nxt = fee_value; // RULE_11
            default:
                rd_mux_nxt = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial frame: 7 address bits MSB first, read flag, 8 data bits.
    // Host samples on sclk rise, so read data moves on the fall.
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= ST_IDLE;
            sclk_d_r <= 1'b0;
            sle_d_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            hdr_sh_r <= 7'h00;
            addr_r <= 7'h00;
            rd_r <= 1'b0;
            wr_sh_r <= 7'h00;
            rd_sh_r <= 8'h00;
            wr_stb_r <= 1'b0;
            wr_data_r <= 8'h00;
            sdata_out <= 1'b0;
            sdata_oe <= 1'b0;
        end
        else
        begin
            sclk_d_r <= sclk;
            sle_d_r <= sle;
            wr_stb_r <= 1'b0;
            if (!sle)
            begin
                // Dropping enable aborts a frame without writing
                state_r <= ST_IDLE;
                sdata_oe <= 1'b0;
            end
            else
            begin
                case (state_r)
                    ST_IDLE:
                        if (sle_rise)
                        begin
                            state_r <= ST_HDR;
                            bit_cnt_r <= 3'h0;
                        end
                    ST_HDR:
                        if (sclk_rise)
                        begin
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == `TCR_HDR_LAST)
                            begin
                                addr_r <= hdr_sh_r;
                                rd_r <= sdata_in;
                                state_r <= ST_DATA;
                                bit_cnt_r <= 3'h0;
                                if (sdata_in)
                                begin
                                    rd_sh_r <= {rd_mux_nxt[6:0], 1'b0};
                                    sdata_out <= rd_mux_nxt[7];
                                    sdata_oe <= 1'b1;
                                end
                            end
                            else
                                hdr_sh_r <= {hdr_sh_r[5:0], sdata_in};
                        end
                    ST_DATA:
                    begin
                        if (sclk_rise)
                        begin
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            wr_sh_r <= {wr_sh_r[5:0], sdata_in};
                            if (bit_cnt_r == `TCR_DATA_LAST)
                            begin
                                state_r <= ST_IDLE;
                                sdata_oe <= 1'b0;
                                wr_stb_r <= ~rd_r;
                                wr_data_r <= {wr_sh_r, sdata_in};
                            end
                        end
                        else if (sclk_fall && rd_r && bit_cnt_r != 3'h0)
                        begin
                            sdata_out <= rd_sh_r[7];
                            rd_sh_r <= {rd_sh_r[6:0], 1'b0};
                        end
                    end
                    default:
                        state_r <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes; reserved bits are masked off so they store nothing
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            a_div_r <= `TCR_RST_A_DIV;
            n_high_r <= `TCR_RST_DIV;
            n_low_r <= `TCR_RST_DIV;
            m_high_r <= `TCR_RST_DIV;
            m_low_r <= `TCR_RST_DIV;
            bias_r <= `TCR_RST_BIAS;
            fee_ctrl_r <= `TCR_RST_FEE_CTRL;
        end
        else if (wr_stb_r)
        begin
            case (addr_r)
                `TCR_OFF_A_DIV:
                    a_div_r <= wr_data_r & `TCR_MASK_A_DIV; // RULE_13
                `TCR_OFF_N_HIGH:
                    n_high_r <= wr_data_r & `TCR_MASK_DIV_HIGH; // RULE_13
                `TCR_OFF_N_LOW:
                    n_low_r <= wr_data_r;
                `TCR_OFF_M_HIGH:
                    m_high_r <= wr_data_r & `TCR_MASK_DIV_HIGH; // RULE_13
                `TCR_OFF_M_LOW:
                    m_low_r <= wr_data_r;
                `TCR_OFF_BIAS:
                    bias_r <= wr_data_r;
                `TCR_OFF_FEE_CTRL:
                    fee_ctrl_r <= wr_data_r & `TCR_MASK_FEE_CTRL; // RULE_13
                default:
                    a_div_r <= a_div_r;
            endcase
        end
    end

    assign second_swallow_count = a_div_r[5:0];
    assign second_feedback_count = {n_high_r[3:0], n_low_r};
    assign second_reference_count = {m_high_r[3:0], m_low_r};
    assign bias_value = bias_r;
    assign fee_clear = wr_stb_r && (addr_r == `TCR_OFF_FEE_CTRL);

    ////////////////////////////////////////////////////////////////////////
    // Error estimator counts only while receiving
    tcr_fee_counter u_fee
    (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .fee_mode(fee_ctrl_r[1:0]),
        .count_en(rx_on),
        .count_clear(fee_clear),
        .up_pulse(fee_up_pulse),
        .dn_pulse(fee_dn_pulse),
        .fee_value(fee_value)
    );

    ////////////////////////////////////////////////////////////////////////
    // Main state and modulation decode, registered for clean outputs.
    // Power down leaves the register bank untouched.
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pwr_down <= 1'b1;
            xco_on <= 1'b0;
            rx_on <= 1'b0;
            tx_on <= 1'b0;
            pa_on <= 1'b0;
            bit_sync_on <= 1'b0;
            mod_closed_loop <= 1'b0;
            mod_open_loop <= 1'b0;
            mod_divider <= 1'b0;
            mod_reserved <= 1'b0;
            bias_fault <= 1'b0;
        end
        else
        begin
            pwr_down <= (main_state == `TCR_MAIN_POWER_DOWN); // RULE_01
            xco_on <= (main_state != `TCR_MAIN_POWER_DOWN); // RULE_01
            rx_on <= (main_state == `TCR_MAIN_RECEIVE); // RULE_01
            tx_on <= (main_state == `TCR_MAIN_TRANSMIT); // RULE_01
            // Transmit state excludes the amplifier stage
            pa_on <= 1'b0; // RULE_01
            bit_sync_on <= sync_en && main_state[1]; // RULE_04
            mod_closed_loop <= (mod_method == `TCR_MOD_CLOSED); // RULE_05
            mod_open_loop <= (mod_method == `TCR_MOD_OPEN); // RULE_05
            mod_divider <= (mod_method == `TCR_MOD_DIVIDER); // RULE_05
            // Flags a host slip; the code still selects nothing
            mod_reserved <= (mod_method == `TCR_MOD_RESERVED); // RULE_06
            bias_fault <= (bias_r != `TCR_BIAS_REQUIRED); // RULE_07
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit clock divider; rx realigns to half a bit on each data edge outside a bit_tick cycle
    assign bit_tick = (bit_cnt_div_r == BIT_DIV - 1);

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            bit_cnt_div_r <= 16'h0000;
            demod_d_r <= 1'b0;
        end
        else
        begin
            demod_d_r <= demod_data;
            if (!bit_sync_on || bit_tick)
                bit_cnt_div_r <= 16'h0000;
            else if (rx_on && (demod_data != demod_d_r))
                bit_cnt_div_r <= HALF_DIV[15:0]; // RULE_04
            else
                bit_cnt_div_r <= bit_cnt_div_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data paths; transparent without sync, bit-timed with it
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_data <= 1'b0;
            tx_data_mod <= 1'b0;
            bit_clock_pin_out <= 1'b0;
            bit_clock_pin_oe <= 1'b0;
            div_alt_sel <= 1'b0;
        end
        else
        begin
            if (!bit_sync_on)
                rx_data <= demod_data; // RULE_02
            else if (rx_on && bit_tick)
                rx_data <= demod_data; // RULE_04
            if (!bit_sync_on)
                tx_data_mod <= tx_data_in; // RULE_03
            else if (tx_on && bit_tick)
                tx_data_mod <= tx_data_in; // RULE_04
            // Pin idles low and undriven unless transmitting with sync
            bit_clock_pin_oe <= tx_on && bit_sync_on; // RULE_03
            bit_clock_pin_out <= tx_on && bit_sync_on &&
                (bit_cnt_div_r < HALF_DIV[15:0]); // RULE_04
            // Divider sets switch with the data only in divider mode
            div_alt_sel <= tx_on && mod_divider && tx_data_mod; // RULE_05
        end
    end
endmodule // tcr_config_regs

// File: rtl/tcr_defs.vh
// Constants of the transceiver configuration register bank.
// Assumes inclusion by bare name from the design files.
`ifndef TCR_DEFS_VH
`define TCR_DEFS_VH

// Register addresses on the three-wire port, 7 bits
`define TCR_ADDR_W 7
`define TCR_OFF_A_DIV 7'h0F
`define TCR_OFF_N_HIGH 7'h10
`define TCR_OFF_N_LOW 7'h11
`define TCR_OFF_M_HIGH 7'h12
`define TCR_OFF_M_LOW 7'h13
`define TCR_OFF_BIAS 7'h14
`define TCR_OFF_FEE_CTRL 7'h15
`define TCR_OFF_FEE_VALUE 7'h16

// Writable bit masks; reserved bits store nothing and read zero
`define TCR_MASK_A_DIV 8'h3F
`define TCR_MASK_DIV_HIGH 8'h0F
`define TCR_MASK_FEE_CTRL 8'h0F

// Reset values
`define TCR_RST_A_DIV 8'h00
`define TCR_RST_DIV 8'h00
`define TCR_RST_BIAS 8'hB5
`define TCR_RST_FEE_CTRL 8'h00

// Mandatory content of the bias-setting register
`define TCR_BIAS_REQUIRED 8'hB5

// Main state codes
`define TCR_MAIN_POWER_DOWN 2'h0
`define TCR_MAIN_STANDBY 2'h1
`define TCR_MAIN_RECEIVE 2'h2
`define TCR_MAIN_TRANSMIT 2'h3

// Modulation method codes
`define TCR_MOD_CLOSED 2'h0
`define TCR_MOD_OPEN 2'h1
`define TCR_MOD_DIVIDER 2'h2
`define TCR_MOD_RESERVED 2'h3

// Error estimator counting modes
`define TCR_FEE_OFF 2'h0
`define TCR_FEE_UP 2'h1
`define TCR_FEE_DOWN 2'h2
`define TCR_FEE_BOTH 2'h3

// Serial frame: address bits plus read flag, then data bits
`define TCR_HDR_LAST 3'h7
`define TCR_DATA_LAST 3'h7

// Bit clock divider default, system cycles per bit
`define TCR_BIT_DIV 16

`endif

// File: rtl/tcr_fee_counter.v
// Frequency-error estimator counter.
// Assumes up and down pulses are one-cycle, synchronous to clk_sys.
`timescale 1ns/1ps
`include "tcr_defs.vh"

module tcr_fee_counter
(
    clk_sys,
    rstn,
    fee_mode,
    count_en,
    count_clear,
    up_pulse,
    dn_pulse,
    fee_value
);
    input wire clk_sys;
    input wire rstn;
    input wire [1:0] fee_mode;
    input wire count_en;
    input wire count_clear;
    input wire up_pulse;
    input wire dn_pulse;
    output reg [7:0] fee_value;

    reg [7:0] fee_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Next count; wraps modulo 256, software reads two's complement
    always @*
    begin
        fee_nxt = fee_value;
        case (fee_mode)
            `TCR_FEE_OFF:
                fee_nxt = fee_value;
            `TCR_FEE_UP:
                if (up_pulse)
                    fee_nxt = fee_value + 8'h01; // RULE_12
            `TCR_FEE_DOWN:
                if (dn_pulse)
                    fee_nxt = fee_value + 8'h01; // RULE_12
            `TCR_FEE_BOTH:
                // Coincident pulses cancel
                if (up_pulse && !dn_pulse)
                    fee_nxt = fee_value + 8'h01; // RULE_12
                else if (dn_pulse && !up_pulse)
                    fee_nxt = fee_value - 8'h01; // RULE_12
            default:
                fee_nxt = fee_value;
        endcase
    end

    // Clear beats counting so a fresh measurement starts at zero
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            fee_value <= 8'h00;
        else if (count_clear)
            fee_value <= 8'h00;
        else if (count_en)
            fee_value <= fee_nxt; // RULE_11
    end
endmodule // tcr_fee_counter

// File: verif/tb_transceiver_config_registers.sv
// Self-checking bench of the configuration register bank.
// Assumes the host model owns sclk, sle and the data line.
`timescale 1ns/1ps
`include "tcr_defs.vh"
module tb_transceiver_config_registers;
    reg clk_sys = 1'b0;
    reg rstn = 1'b0;
    reg main_state_hi = 1'b0, main_state_lo = 1'b0, sync_en = 1'b0;
    reg mod_method_hi = 1'b0, mod_method_lo = 1'b0, demod_data = 1'b0;
    reg fee_up_pulse = 1'b0, fee_dn_pulse = 1'b0, tx_data_in = 1'b0;
    wire sclk, sle, sdata_in, sdata_out, sdata_oe, rx_data, tx_data_mod;
    wire bit_clock_pin_out, bit_clock_pin_oe, pwr_down, xco_on, rx_on;
    wire tx_on, pa_on, bit_sync_on, mod_closed_loop, mod_open_loop;
    wire mod_divider, mod_reserved, div_alt_sel, bias_fault;
    wire [5:0] second_swallow_count;
    wire [11:0] second_feedback_count, second_reference_count;
    wire [7:0] bias_value;
    integer err_count = 0;
    integer comparisons = 0;
    integer cycles = 0;
    integer i, j;
    reg [7:0] rd;
    // Short bit divider keeps the synchronizer runs brief
    tcr_config_regs #(.BIT_DIV(4)) tcr_config_regs_i (.*);
    tcr_host_model tcr_host_model_i (.*);
    always #20 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////
    task check(input string what, input [11:0] seen, input [11:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    task wr(input [6:0] addr, input [7:0] data);
        tcr_host_model_i.xfer(addr, 1'b0, data, 16, rd);
    endtask
    task rdchk(input [6:0] addr, input [7:0] exp);
    begin
        tcr_host_model_i.xfer(addr, 1'b1, 8'h00, 16, rd);
        check("readback", {4'h0, rd}, {4'h0, exp});
    end
    endtask
    task tally_and_finish;
    begin
        $display("Comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    // Hang guard; the whole run needs well under 20000 cycles
    always @(posedge clk_sys)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            err_count = err_count + 1;
            tally_and_finish;
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (4) @(negedge clk_sys);
        // Reset contents, then one unmapped address reading zero
        for (i = 0; i < 9; i = i + 1)
            rdchk(7'h0F + i, (i == 5) ? 8'hB5 : 8'h00);
        check("bias_flag", bias_fault, 12'h000);
        wr(`TCR_OFF_A_DIV, 8'h2A);
        wr(`TCR_OFF_N_HIGH, 8'h0A);
        wr(`TCR_OFF_N_LOW, 8'h5C);
        wr(`TCR_OFF_M_HIGH, 8'h03);
        wr(`TCR_OFF_M_LOW, 8'hC1);
        wr(`TCR_OFF_BIAS, `TCR_BIAS_REQUIRED);
        check("bias", {4'h0, bias_value}, 12'h0B5);
        check("reference", second_reference_count, 12'h3C1);
        rdchk(`TCR_OFF_M_HIGH, 8'h03);
        // Frame cut short must leave the swallow count alone
        tcr_host_model_i.xfer(`TCR_OFF_A_DIV, 1'b0, 8'h11, 12, rd);
        check("swallow", {6'h00, second_swallow_count}, 12'h02A);
        wr(`TCR_OFF_FEE_VALUE, 8'h55);
        rdchk(`TCR_OFF_FEE_VALUE, 8'h00);
        // Every main state; power down must keep the dividers
        for (i = 0; i < 4; i = i + 1)
        begin
            {main_state_hi, main_state_lo} = i[1:0];
            repeat (2) @(negedge clk_sys);
            check("state", {pwr_down, xco_on, rx_on, tx_on, pa_on},
                {i == 0, i != 0, i == 2, i == 3, 1'b0});
            check("kept", second_feedback_count, 12'hA5C);
        end
        // Defined modulation codes only; code 11 is never driven
        for (i = 0; i < 3; i = i + 1)
        begin
            {mod_method_hi, mod_method_lo} = i[1:0];
            repeat (2) @(negedge clk_sys);
            check("mod", {mod_closed_loop, mod_open_loop, mod_divider,
                mod_reserved}, 12'h8 >> i);
        end
        // Estimator modes: 3 up then 5 down pulses, mode 3 wraps to FE
        {main_state_hi, main_state_lo} = `TCR_MAIN_RECEIVE;
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(`TCR_OFF_FEE_CTRL, i[7:0]);
            for (j = 0; j < 8; j = j + 1)
            begin
                fee_up_pulse = (j < 3);
                fee_dn_pulse = (j >= 3);
                @(negedge clk_sys);
                fee_up_pulse = 1'b0;
                fee_dn_pulse = 1'b0;
                @(negedge clk_sys);
            end
            rdchk(`TCR_OFF_FEE_VALUE, (i == 0) ? 8'h00 : (i == 1) ? 8'h03 :
                (i == 2) ? 8'h05 : 8'hFE);
        end
        // Receive and transmit, each without and with the synchronizer
        for (i = 0; i < 4; i = i + 1)
        begin
            sync_en = i[0];
            {main_state_hi, main_state_lo} = {1'b1, i[1]};
            for (j = 0; j < 40; j = j + 1)
            begin
                demod_data = j[2];
                tx_data_in = j[1];
                @(negedge clk_sys);
            end
            check("pin_oe", bit_clock_pin_oe, i == 3);
            check("sync", bit_sync_on, i[0]);
            if (!i[0])
            begin
                check("through", i[1] ? tx_data_mod : rx_data,
                    i[1] ? tx_data_in : demod_data);
                check("alt_sel", div_alt_sel, i == 2);
            end
        end
        tally_and_finish;
    end
endmodule // tb_transceiver_config_registers

// File: verif/tcr_config_regs_sva.sv
// Assertions on the ports of the configuration register bank.
// Assumes a single clk_sys domain with asynchronous rstn.
`timescale 1ns/1ps
`include "tcr_defs.vh"
module tcr_config_regs_sva
#(
    parameter BIT_DIV = 16
)
(
    input wire clk_sys,
    input wire rstn,
    input wire sle,
    input wire sdata_oe,
    input wire main_state_hi,
    input wire main_state_lo,
    input wire sync_en,
    input wire mod_method_hi,
    input wire mod_method_lo,
    input wire demod_data,
    input wire tx_data_in,
    input wire rx_data,
    input wire tx_data_mod,
    input wire bit_clock_pin_out,
    input wire bit_clock_pin_oe,
    input wire pwr_down,
    input wire rx_on,
    input wire tx_on,
    input wire pa_on,
    input wire bit_sync_on,
    input wire mod_closed_loop,
    input wire mod_open_loop,
    input wire mod_divider,
    input wire mod_reserved,
    input wire [7:0] bias_value,
    input wire bias_fault
);
    localparam int HIGH_LAST = BIT_DIV / 2 - 1;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    reg [1:0] live_r;
    reg [2:0] mode_d_r;
    reg [2:0] mode_dd_r;
    // Mode history; decodes may lag by two cycles, so demand a steady mode
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            live_r <= 2'h0;
        else if (live_r != 2'h2)
            live_r <= live_r + 2'h1;
    end
    always @(posedge clk_sys)
    begin
        mode_d_r <= {sync_en, main_state_hi, main_state_lo};
        mode_dd_r <= mode_d_r;
    end
    wire live = (live_r == 2'h2);
    wire steady = live && (mode_d_r == mode_dd_r);
    ////////////////////////////////////////////////////////////////////
    a_state_decode: assert property (live |->
        pwr_down == $past(!main_state_hi && !main_state_lo) &&
        rx_on == $past(main_state_hi && !main_state_lo) &&
        tx_on == $past(main_state_hi && main_state_lo))
        else $error("state decode wrong");
    a_pa_excluded: assert property (!pa_on)
        else $error("amplifier stage on");
    a_rx_through: assert property (steady && mode_d_r == 3'h2 |->
        rx_data == $past(demod_data)) else $error("rx data not direct");
    a_tx_through: assert property (steady && mode_d_r == 3'h3 |->
        tx_data_mod == $past(tx_data_in) && !bit_clock_pin_oe)
        else $error("tx data not direct");
    a_pin_enable: assert property (steady |->
        bit_clock_pin_oe == (mode_d_r == 3'h7))
        else $error("clock pin enable wrong");
    a_sync_decode: assert property (live |->
        bit_sync_on == $past(sync_en && main_state_hi))
        else $error("sync decode wrong");
    a_clock_shape: assert property (steady && mode_d_r == 3'h7 &&
        $rose(bit_clock_pin_out) |-> ##HIGH_LAST bit_clock_pin_out
        ##1 !bit_clock_pin_out) else $error("bit clock high time wrong");
    a_mod_decode: assert property (live |->
        {mod_closed_loop, mod_open_loop, mod_divider, mod_reserved} ==
        (4'h8 >> $past({mod_method_hi, mod_method_lo})))
        else $error("modulation decode wrong");
    a_read_release: assert property (live && !sle && !$past(sle) |->
        !sdata_oe) else $error("data line driven outside frame");
    a_bias_check: assert property (live |->
        bias_fault == ($past(bias_value) != `TCR_BIAS_REQUIRED))
        else $error("bias flag wrong");
endmodule // tcr_config_regs_sva
bind tcr_config_regs tcr_config_regs_sva #(.BIT_DIV(BIT_DIV))
    tcr_config_regs_sva_i (.clk_sys(clk_sys), .rstn(rstn), .sle(sle),
    .sdata_oe(sdata_oe), .main_state_hi(main_state_hi),
    .main_state_lo(main_state_lo), .sync_en(sync_en),
    .mod_method_hi(mod_method_hi), .mod_method_lo(mod_method_lo),
    .demod_data(demod_data), .tx_data_in(tx_data_in), .rx_data(rx_data),
    .tx_data_mod(tx_data_mod), .bit_clock_pin_out(bit_clock_pin_out),
    .bit_clock_pin_oe(bit_clock_pin_oe), .pwr_down(pwr_down),
    .rx_on(rx_on), .tx_on(tx_on), .pa_on(pa_on), .bit_sync_on(bit_sync_on),
    .mod_closed_loop(mod_closed_loop), .mod_open_loop(mod_open_loop),
    .mod_divider(mod_divider), .mod_reserved(mod_reserved),
    .bias_value(bias_value), .bias_fault(bias_fault));

// File: verif/tcr_host_model.sv
// Host controller model on the three-wire port of the register bank.
// Assumes the bench calls xfer and that sclk halves last 3 clk_sys.
`timescale 1ns/1ps
module tcr_host_model
(
    input wire clk_sys,
    output reg sclk,
    output reg sle,
    output wire sdata_in,
    input wire sdata_out,
    input wire sdata_oe
);
    reg host_bit;
    reg host_oe;
    initial
    begin
        sclk = 1'b0;
        sle = 1'b0;
        host_bit = 1'b0;
        host_oe = 1'b0;
    end
    // Released line shows the inverse of the last bit, never a stale copy
    assign sdata_in = sdata_oe ? sdata_out : (host_oe ? host_bit : ~host_bit);
    ////////////////////////////////////////////////////////////////////
    // One frame: address, read flag, data; fewer than 16 bits aborts
    task xfer(input [6:0] addr, input rd, input [7:0] wdata,
        input integer nbits, output [7:0] rdata);
        reg [15:0] frame;
        integer i;
    begin
        frame = {addr, rd, wdata};
        rdata = 8'h00;
        @(negedge clk_sys) sle = 1'b1;
        repeat (3) @(negedge clk_sys);
        for (i = 0; i < nbits; i = i + 1)
        begin
            host_oe = !(rd && i > 7);
            if (host_oe)
                host_bit = frame[15 - i];
            repeat (3) @(negedge clk_sys);
            if (i > 7)
                rdata[15 - i] = sdata_in;
            sclk = 1'b1;
            repeat (3) @(negedge clk_sys);
            sclk = 1'b0;
        end
        repeat (3) @(negedge clk_sys);
        sle = 1'b0;
        host_oe = 1'b0;
        repeat (4) @(negedge clk_sys);
    end
    endtask
endmodule // tcr_host_model
